// >>> core/gfx_arb_pkg.sv
package gfx_arb_pkg;
	// Configuration-space byte offsets
	localparam logic [7:0] OFS_PRIO_CTRL = 8'h84;
	localparam logic [7:0] OFS_BOUND_A20 = 8'h88;
	localparam logic [7:0] OFS_CPU_CTRL = 8'h89;
	localparam logic [7:0] OFS_BOUND_FINE = 8'hA0;
	localparam logic [7:0] OFS_LINK_CTRL = 8'hA1;
	localparam logic [7:0] OFS_WINDOW_CTRL = 8'hA2;
	localparam logic [7:0] OFS_HOLE_ADDR = 8'hA3;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;
	// shared_memory_cpu_ctrl fields
	localparam int CPU_PCI_HOLD_BIT = 7;
	localparam int CPU_ASYNC_BIT = 6;
	localparam int CPU_LAT60_BIT = 5;
	localparam int CPU_ALT_MAP_BIT = 4;
	localparam int CPU_SIZE_LSB = 1;
	localparam int CPU_ENABLE_BIT = 0;
	// graphics_link_ctrl fields
	localparam int LINK_PIN_SEL_BIT = 5;
	localparam int LINK_BANK_LSB = 2;
	localparam int LINK_MIN_WIDTH_BIT = 1;
	localparam int LINK_ONE_PRIO_BIT = 0;
	localparam logic [7:0] LINK_RW_MASK = 8'h3F;
	// direct_window_ctrl fields
	localparam int WIN_ADDR_LSB = 3;
	localparam int WIN_RD_BIT = 2;
	localparam int WIN_WR_BIT = 1;
	localparam int WIN_PCI_BIT = 0;
	// three_pin_priority_ctrl field
	localparam int PRIO_PIN_BIT = 0;
	// Timing in host clocks
	localparam logic [7:0] GRANT_DELAY = 8'h02;
	localparam logic [7:0] RECLAIM_DELAY = 8'h03;
	localparam logic [7:0] MIN_GRANT = 8'h10;
	localparam logic [7:0] LAT_HIGH = 8'h1E;
	localparam logic [7:0] LAT_LOW = 8'h3C;
	localparam logic [7:0] LAT_MARGIN = 8'h08;

	typedef enum logic [2:0] {
		ARB_IDLE = 3'b000,
		ARB_WAIT = 3'b001,
		ARB_REARM = 3'b010,
		ARB_GRANT = 3'b011,
		ARB_RECLAIM = 3'b100,
		ARB_DRAIN = 3'b101
	} arb_state_t;
endpackage : gfx_arb_pkg

// >>> core/pin_sync2.sv
`timescale 1ns/100ps
module pin_sync2 #(
	parameter int WIDTH = 2,
	parameter logic [WIDTH-1:0] IDLE = '1
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Pins
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync
);
	logic [WIDTH-1:0] stage1_reg;

	// First stage feeds only the second
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
		begin
			stage1_reg <= IDLE;
			pin_sync <= IDLE;
		end
		else
		begin
			stage1_reg <= pin_in;
			pin_sync <= stage1_reg;
		end
endmodule : pin_sync2

// >>> core/shared_memory_gfx_arbiter.sv
`timescale 1ns/100ps
//Function
// R1 - Synchronous mode: handshake is on the host clock, no synchronizer used.
// R2 - Asynchronous mode: handshake must be resynchronized by one of the sides.
// R3 - Graphics side holds request low while it wants the bus.
// R4 - Grant is driven active low to hand over the bus.
// R5 - Reclaim: grant goes high while request low; graphics then releases.
// R6 - Row, column strobes and write enable float the clock after grant.
// R7 - Fastest installed bank becomes logical bank 0, the shared memory.
// R8 - CPU reg bit 7: 0 grants after write-back, 1 waits for posted writes.
// R9 - CPU reg bit 6: 0 synchronous, 1 asynchronous handshake.
// R10 - CPU reg bit 5: worst wait 30 clocks, or 60 clocks when set.
// R11 - CPU reg bit 4 selects native or alternative address mapping.
// R12 - CPU reg bits 3:1 encode shared size, 0.5M to 4M.
// R13 - CPU reg bit 0 enables shared memory operation.
// R14 - Link reg bit 5 selects which alternate pin carries grant.
// R15 - Link reg bits 4:2 name the bank holding shared memory.
// R16 - Link reg bit 1 holds each grant at least 16 clocks.
// R17 - Link reg bit 0: two-priority or one-priority scheme.
// R18 - Window reg: A23-A19 window plus read, write and PCI enables.
// R19 - Hole reg: A31-A24 hole remapped onto shared memory.
// R20 - Priority reg bit 0 enables the priority request pin.
// R21 - Bank_boundary_a20_bits holds A20 for each of eight bank boundaries.
// R22 - Bank_boundary_fine_resolution refines bank boundaries to 512K granularity.
// R23 - Grant follows a request by two clocks when DRAM is free.
// R24 - Grant releases one clock after request is released.
// R25 - Grant drops three clocks after the chipset needs DRAM.
// R26 - Two-priority: release and reassert means high priority, 30 clocks.
// R27 - Disabled sharing never grants and keeps driving DRAM lines.
// R28 - Asynchronous mode runs request through a two-stage synchronizer.
module shared_memory_gfx_arbiter
	import gfx_arb_pkg::*;
#(
	parameter int NUM_BANKS = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Configuration space access
	input wire logic [7:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	// Graphics handshake pins
	input wire logic gfx_mem_request_n,
	input wire logic gfx_priority_request,
	output logic alt_output_pin_one,
	output logic alt_output_pin_two,
	// Chipset DRAM engine
	input wire logic dram_busy,
	input wire logic host_need,
	input wire logic cpu_writeback_pending,
	input wire logic posted_write_pending,
	input wire logic pci_master_active,
	input wire logic [NUM_BANKS-1:0] bank_present,
	input wire logic [NUM_BANKS-1:0] bank_fast,
	output logic arb_hold,
	output logic pci_disconnect,
	// DRAM control pins
	input wire logic [NUM_BANKS-1:0] ras_n_in,
	input wire logic [7:0] cas_n_in,
	input wire logic we_n_in,
	output logic [NUM_BANKS-1:0] ras_n_out,
	output logic [7:0] cas_n_out,
	output logic dram_write_enable_n,
	output logic dram_ctl_oe,
	// Address routing
	input wire logic [31:0] cpu_addr,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic pci_mst_acc,
	output logic direct_route,
	output logic alt_map_sel,
	output logic [3:0] shared_half_mb,
	output logic [2:0] shared_bank,
	output logic [2:0] fast_bank,
	output logic [7:0] boundary_a20,
	output logic [7:0] boundary_fine
);
	if (NUM_BANKS < 1 || NUM_BANKS > 8)
		$error("NUM_BANKS must lie in 1..8");
	logic [7:0] prio_ctrl_reg;
	logic [7:0] cpu_ctrl_reg;
	logic [7:0] link_ctrl_reg;
	logic [7:0] window_reg;
	logic [7:0] hole_reg;
	arb_state_t state_reg;
	arb_state_t state_next;
	logic [7:0] wait_cnt_reg;
	logic [7:0] wait_cnt_next;
	logic [7:0] grant_cnt_reg;
	logic high_prio_reg;
	logic high_prio_next;
	logic grant_reg;
	logic [1:0] pins_sync;
	// Register decode
	wire hit_prio = cfg_addr == OFS_PRIO_CTRL;
	wire hit_a20 = cfg_addr == OFS_BOUND_A20;
	wire hit_cpu = cfg_addr == OFS_CPU_CTRL;
	wire hit_fine = cfg_addr == OFS_BOUND_FINE;
	wire hit_link = cfg_addr == OFS_LINK_CTRL;
	wire hit_win = cfg_addr == OFS_WINDOW_CTRL;
	wire hit_hole = cfg_addr == OFS_HOLE_ADDR;
	logic [7:0] rd_mux;
	always_comb
	begin
		if (hit_prio)
			rd_mux = prio_ctrl_reg;
		else if (hit_a20)
			rd_mux = boundary_a20; // [R21]
		else if (hit_cpu)
			rd_mux = cpu_ctrl_reg;
		else if (hit_fine)
			rd_mux = boundary_fine; // [R22]
		else if (hit_link)
			rd_mux = link_ctrl_reg & LINK_RW_MASK;
		else if (hit_win)
			rd_mux = window_reg;
		else if (hit_hole)
			rd_mux = hole_reg;
		else
			rd_mux = UNMAPPED_DATA;
	end
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
		begin
			prio_ctrl_reg <= REG_RESET;
			boundary_a20 <= REG_RESET;
			cpu_ctrl_reg <= REG_RESET;
			boundary_fine <= REG_RESET;
			link_ctrl_reg <= REG_RESET;
			window_reg <= REG_RESET;
			hole_reg <= REG_RESET;
			cfg_rdata <= REG_RESET;
		end
		else
		begin
			if (cfg_wr && hit_prio)
				prio_ctrl_reg <= cfg_wdata;
			if (cfg_wr && hit_a20)
				boundary_a20 <= cfg_wdata;
			if (cfg_wr && hit_cpu)
				cpu_ctrl_reg <= cfg_wdata;
			if (cfg_wr && hit_fine)
				boundary_fine <= cfg_wdata;
			if (cfg_wr && hit_link)
				link_ctrl_reg <= cfg_wdata & LINK_RW_MASK;
			if (cfg_wr && hit_win)
				window_reg <= cfg_wdata;
			if (cfg_wr && hit_hole)
				hole_reg <= cfg_wdata;
			if (cfg_rd)
				cfg_rdata <= rd_mux;
		end
	// Field views
	wire share_en = cpu_ctrl_reg[CPU_ENABLE_BIT];
	wire async_mode = cpu_ctrl_reg[CPU_ASYNC_BIT];
	wire pci_hold = cpu_ctrl_reg[CPU_PCI_HOLD_BIT];
	wire lat60 = cpu_ctrl_reg[CPU_LAT60_BIT];
	wire one_prio = link_ctrl_reg[LINK_ONE_PRIO_BIT];
	wire min_width = link_ctrl_reg[LINK_MIN_WIDTH_BIT];
	wire pin_sel_two = link_ctrl_reg[LINK_PIN_SEL_BIT];
	wire prio_pin_en = prio_ctrl_reg[PRIO_PIN_BIT];
	// Handshake inputs, resynchronized only in asynchronous mode
	pin_sync2 #(
		.WIDTH(2),
		.IDLE(2'b01)
	) u_sync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.pin_in({gfx_priority_request, gfx_mem_request_n}),
		.pin_sync(pins_sync)
	);
	// Synchronous mode takes pins raw: they already move on clk_sys
	wire req_n = async_mode ? pins_sync[0] : gfx_mem_request_n; // [R1] [R2] [R9] [R28]
	wire prio_in = async_mode ? pins_sync[1] : gfx_priority_request; // [R9]
	wire req = !req_n && share_en; // [R3] [R13]
	// Latency bound; high priority always uses the short one
	wire [7:0] lat_bound = (high_prio_reg || !lat60) ? LAT_HIGH : LAT_LOW; // [R10] [R26]
	wire urgent = wait_cnt_reg >= lat_bound - LAT_MARGIN; // [R10]
	// Bit 7 clear lets the grant go once the write-back drains
	wire flush_done = pci_hold ? !posted_write_pending
		: !cpu_writeback_pending; // [R8]
	wire bus_free = !dram_busy && (flush_done || urgent);
	wire delay_done = wait_cnt_reg >= GRANT_DELAY - 8'h01; // [R23]
	wire reclaim_done = wait_cnt_reg >= RECLAIM_DELAY - 8'h01; // [R25]
	wire width_ok = !min_width || grant_cnt_reg >= MIN_GRANT; // [R16]
	always_comb
	begin
		state_next = state_reg;
		wait_cnt_next = wait_cnt_reg + 8'h01;
		high_prio_next = high_prio_reg;
		case (state_reg)
			ARB_IDLE:
			begin
				wait_cnt_next = 8'h00;
				high_prio_next = 1'b0;
				if (req)
					state_next = ARB_WAIT;
			end
			ARB_WAIT:
			begin
				if (prio_pin_en && prio_in)
					high_prio_next = 1'b1; // [R20]
				if (!req)
					state_next = one_prio ? ARB_IDLE : ARB_REARM; // [R17]
				else if (delay_done && bus_free)
				begin
					state_next = ARB_GRANT; // [R4] [R23]
					wait_cnt_next = 8'h00;
				end
			end
			ARB_REARM:
			begin
				if (!share_en)
					state_next = ARB_IDLE;
				else if (req)
				begin
					state_next = ARB_WAIT; // [R26]
					high_prio_next = 1'b1;
				end
			end
			ARB_GRANT:
			begin
				wait_cnt_next = 8'h00;
				if (!req && width_ok)
					state_next = ARB_IDLE; // [R24]
				else if (host_need)
					state_next = ARB_RECLAIM; // [R25]
			end
			ARB_RECLAIM:
			begin
				if (!req && width_ok)
					state_next = ARB_IDLE;
				else if (reclaim_done && width_ok)
					state_next = ARB_DRAIN; // [R5] [R25]
			end
			ARB_DRAIN:
			begin
				wait_cnt_next = 8'h00;
				if (!req)
					state_next = ARB_IDLE; // [R5]
			end
			default:
				state_next = ARB_IDLE;
		endcase
	end
	wire grant_on = state_next == ARB_GRANT || state_next == ARB_RECLAIM;
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
		begin
			state_reg <= ARB_IDLE;
			wait_cnt_reg <= 8'h00;
			high_prio_reg <= 1'b0;
			grant_reg <= 1'b0;
			grant_cnt_reg <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			wait_cnt_reg <= wait_cnt_next;
			high_prio_reg <= high_prio_next;
			grant_reg <= grant_on && share_en; // [R27]
			if (!grant_on)
				grant_cnt_reg <= 8'h00;
			else if (grant_cnt_reg != 8'hFF)
				grant_cnt_reg <= grant_cnt_reg + 8'h01;
		end
	// Grant pin steering and DRAM line release
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
		begin
			alt_output_pin_one <= 1'b1;
			alt_output_pin_two <= 1'b1;
			dram_ctl_oe <= 1'b1;
			ras_n_out <= '1;
			cas_n_out <= 8'hFF;
			dram_write_enable_n <= 1'b1;
			arb_hold <= 1'b0;
			pci_disconnect <= 1'b0;
		end
		else
		begin
			alt_output_pin_one <= !(grant_on && share_en && !pin_sel_two); // [R14]
			alt_output_pin_two <= !(grant_on && share_en && pin_sel_two); // [R14]
			// Lines go high while granting, then float one clock later
			dram_ctl_oe <= !grant_reg; // [R6] [R27]
			ras_n_out <= grant_on ? '1 : ras_n_in;
			cas_n_out <= grant_on ? 8'hFF : cas_n_in;
			dram_write_enable_n <= grant_on ? 1'b1 : we_n_in;
			arb_hold <= state_next == ARB_WAIT;
			pci_disconnect <= state_next == ARB_WAIT && !pci_hold
				&& pci_master_active; // [R8]
		end
	// Shared area description
	function automatic logic [3:0] size_units(input logic [2:0] code);
		size_units = (code == 3'b000) ? 4'h2 : (code == 3'b001) ? 4'h1
			: {1'b0, code} + 4'h1; // [R12]
	endfunction : size_units
	function automatic logic [2:0] first_set(input logic [NUM_BANKS-1:0] v);
		first_set = 3'b000;
		for (int i = NUM_BANKS - 1; i >= 0; i--)
			if (v[i])
				first_set = 3'(i);
	endfunction : first_set

	// EDO banks win; with none, the first populated bank serves
	wire [NUM_BANKS-1:0] fast_present = bank_present & bank_fast;
	wire [2:0] fast_pick = (|fast_present) ? first_set(fast_present)
		: first_set(bank_present); // [R7]

	// Direct window and hole decode
	wire win_hit = cpu_addr[23:19] == window_reg[7:WIN_ADDR_LSB]; // [R18]
	wire win_use = win_hit && ((cpu_rd && window_reg[WIN_RD_BIT])
		|| (cpu_wr && window_reg[WIN_WR_BIT])
		|| (pci_mst_acc && window_reg[WIN_PCI_BIT])); // [R18]
	wire hole_use = cpu_addr[31:24] == hole_reg
		&& (cpu_rd || cpu_wr || pci_mst_acc); // [R19]

	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
		begin
			direct_route <= 1'b0;
			alt_map_sel <= 1'b0;
			shared_half_mb <= 4'h0;
			shared_bank <= 3'b000;
			fast_bank <= 3'b000;
		end
		else
		begin
			direct_route <= share_en && (win_use || hole_use); // [R18] [R19]
			alt_map_sel <= cpu_ctrl_reg[CPU_ALT_MAP_BIT]; // [R11]
			shared_half_mb <= size_units(cpu_ctrl_reg[3:CPU_SIZE_LSB]); // [R12]
			shared_bank <= link_ctrl_reg[4:LINK_BANK_LSB]; // [R15]
			fast_bank <= fast_pick; // [R7]
		end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	chk_grant_needs_enable: assert property ( // [R27]
		!share_en |=> alt_output_pin_one && alt_output_pin_two)
		else $error("grant asserted with sharing disabled");
	chk_grant_two_clocks: assert property ( // [R23]
		state_reg == ARB_IDLE && req |=> !grant_on)
		else $error("grant came sooner than two clocks");
	chk_float_after_grant: assert property ( // [R6]
		$rose(grant_reg) |=> !dram_ctl_oe)
		else $error("DRAM lines not floated after grant");
	chk_drive_while_idle: assert property ( // [R6]
		!grant_reg |=> dram_ctl_oe)
		else $error("DRAM lines floated without grant");
	chk_release_one_clock: assert property ( // [R24]
		state_reg == ARB_GRANT && !req && width_ok |=> !grant_reg)
		else $error("grant held after request release");
	chk_reclaim_three: assert property ( // [R25]
		state_reg == ARB_GRANT && host_need && req && !min_width
		##1 req [*3] |=> state_reg == ARB_DRAIN)
		else $error("reclaim not three clocks");
	chk_min_width_16: assert property ( // [R16]
		$fell(grant_reg) && min_width |-> $past(grant_cnt_reg) >= MIN_GRANT)
		else $error("grant shorter than 16 clocks");
	chk_pin_select: assert property ( // [R14]
		pin_sel_two |=> alt_output_pin_one)
		else $error("grant on unselected pin");
	chk_size_code: assert property ( // [R12]
		cpu_ctrl_reg[3:1] == 3'b000 |=> shared_half_mb == 4'h2)
		else $error("size code 000 not 1M");
endmodule : shared_memory_gfx_arbiter

// >>> tb/gfx_partner_model.sv
`timescale 1ns/100ps
module gfx_partner_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Bench side
	input wire logic want_bus,
	output logic reclaim_seen,
	// Handshake pins
	input wire logic grant_n,
	output logic gfx_mem_request_n
);
	logic want_s;
	logic grant_s;
	logic owned;
	// One process drives the pins; they settle on the first edge in reset
	// Sample on the edge, move pins just after it, host clock only
	always @(posedge clk_sys)
	begin
		want_s = want_bus;
		grant_s = grant_n;
		#1;
		if (!reset_n)
		begin
			gfx_mem_request_n = 1'b1;
			reclaim_seen = 1'b0;
			owned = 1'b0;
		end
		else if (owned && grant_s && !gfx_mem_request_n)
		begin
			// Grant withdrawn under us: hand the bus back at once
			gfx_mem_request_n = 1'b1;
			reclaim_seen = 1'b1;
		end
		else
		begin
			owned = !grant_s && !gfx_mem_request_n;
			if (!want_s)
				reclaim_seen = 1'b0;
			gfx_mem_request_n = !(want_s && !reclaim_seen);
		end
	end
endmodule : gfx_partner_model

// >>> tb/shared_memory_gfx_arbiter_tb_top.sv
`timescale 1ns/100ps
module shared_memory_gfx_arbiter_tb_top;
	import gfx_arb_pkg::*;
	logic clk_sys, reset_n, cfg_wr, cfg_rd, gfx_mem_request_n;
	logic [7:0] cfg_addr, cfg_wdata, cfg_rdata;
	logic gfx_priority_request, alt_output_pin_one, alt_output_pin_two;
	logic dram_busy, host_need, cpu_writeback_pending;
	logic posted_write_pending, pci_master_active, arb_hold;
	logic pci_disconnect, we_n_in, dram_write_enable_n, dram_ctl_oe;
	logic [7:0] bank_present, bank_fast, ras_n_in, cas_n_in;
	logic [7:0] ras_n_out, cas_n_out, boundary_a20, boundary_fine;
	logic [31:0] cpu_addr;
	logic cpu_rd, cpu_wr, pci_mst_acc, direct_route, alt_map_sel;
	logic [3:0] shared_half_mb;
	logic [2:0] shared_bank, fast_bank;
	logic want_bus, reclaim_seen, grant_n;
	int fail_count = 0;
	int comparisons = 0;
	int n;
	logic [7:0] offs [7] = '{OFS_PRIO_CTRL, OFS_BOUND_A20, OFS_CPU_CTRL,
		OFS_BOUND_FINE, OFS_LINK_CTRL, OFS_WINDOW_CTRL, OFS_HOLE_ADDR};

	assign grant_n = alt_output_pin_one & alt_output_pin_two;

	shared_memory_gfx_arbiter #(.NUM_BANKS(8)) i_dut (
		.clk_sys, .reset_n, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_wdata,
		.cfg_rdata, .gfx_mem_request_n, .gfx_priority_request,
		.alt_output_pin_one, .alt_output_pin_two, .dram_busy, .host_need,
		.cpu_writeback_pending, .posted_write_pending, .pci_master_active,
		.bank_present, .bank_fast, .arb_hold, .pci_disconnect, .ras_n_in,
		.cas_n_in, .we_n_in, .ras_n_out, .cas_n_out, .dram_write_enable_n,
		.dram_ctl_oe, .cpu_addr, .cpu_rd, .cpu_wr, .pci_mst_acc,
		.direct_route, .alt_map_sel, .shared_half_mb, .shared_bank,
		.fast_bank, .boundary_a20, .boundary_fine);

	gfx_partner_model i_gfx (.clk_sys, .reset_n, .want_bus, .reclaim_seen,
		.grant_n, .gfx_mem_request_n);

	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = !clk_sys;
	end

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask : tick

	task automatic check_val(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check_val

	task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
		cfg_addr = a;
		cfg_wdata = d;
		cfg_wr = 1'b1;
		tick(1);
		cfg_wr = 1'b0;
		// Idle cycle so the strobe never toggles twice in one step
		tick(1);
	endtask : cfg_write

	task automatic cfg_check(input logic [7:0] a, input logic [7:0] exp);
		cfg_addr = a;
		cfg_rd = 1'b1;
		tick(1);
		cfg_rd = 1'b0;
		tick(1);
		check_val("cfg_rdata", {24'h0, exp}, {24'h0, cfg_rdata});
	endtask : cfg_check

	// Request sampled extra cycles late when the synchronizer is in
	task automatic acquire(input int extra);
		want_bus = 1'b1;
		tick(3 + extra);
		check_val("grant early", 1, grant_n);
		tick(1);
		check_val("grant", 0, grant_n);
		check_val("ctl idle", 17'h1FFFF,
			{ras_n_out, cas_n_out, dram_write_enable_n});
		tick(1);
		check_val("ctl oe", 0, dram_ctl_oe);
	endtask : acquire

	// Synchronizer delays the sight of the release by extra cycles
	task automatic release_bus(input int extra);
		want_bus = 1'b0;
		tick(1 + extra);
		check_val("grant held", 0, grant_n);
		tick(1);
		check_val("grant off", 1, grant_n);
		tick(1);
		check_val("ctl oe back", 1, dram_ctl_oe);
		tick(2);
	endtask : release_bus

	initial
	begin
		repeat (3000) @(posedge clk_sys);
		fail_count++;
		conclude();
	end

	initial
	begin
		{cfg_addr, cfg_wdata, cfg_wr, cfg_rd, gfx_priority_request} = '0;
		{dram_busy, host_need, cpu_writeback_pending} = '0;
		{posted_write_pending, pci_master_active, want_bus} = '0;
		{cpu_addr, cpu_rd, cpu_wr, pci_mst_acc} = '0;
		bank_present = 8'h34;
		bank_fast = 8'h30;
		ras_n_in = 8'h5A;
		cas_n_in = 8'hC3;
		we_n_in = 1'b0;
		reset_n = 1'b0;
		tick(3);
		reset_n = 1'b1;
		check_val("reset pins", 3'b111,
			{alt_output_pin_one, alt_output_pin_two, dram_ctl_oe});
		foreach (offs[i])
			cfg_check(offs[i], REG_RESET);
		tick(1);
		check_val("ras copy", 8'h5A, ras_n_out);
		check_val("fast bank", 3'h4, fast_bank);
		foreach (offs[i])
			cfg_write(offs[i], 8'hA5);
		foreach (offs[i])
			cfg_check(offs[i], (offs[i] == OFS_LINK_CTRL) ? 8'h25 : 8'hA5);
		cfg_write(8'h90, 8'h77);
		cfg_check(8'h90, UNMAPPED_DATA);
		check_val("a20", 8'hA5, boundary_a20);
		check_val("fine", 8'hA5, boundary_fine);
		cfg_write(OFS_CPU_CTRL, 8'h1D);
		cfg_write(OFS_LINK_CTRL, 8'h14);
		tick(2);
		check_val("alt map", 1, alt_map_sel);
		check_val("size", 4'h7, shared_half_mb);
		check_val("bank", 3'h5, shared_bank);
		cfg_write(OFS_CPU_CTRL, 8'h13);
		tick(2);
		check_val("size half", 4'h1, shared_half_mb);
		cfg_write(OFS_CPU_CTRL, 8'h01);
		cfg_write(OFS_LINK_CTRL, 8'h00);
		tick(2);
		check_val("size 1M", 4'h2, shared_half_mb);
		acquire(0);
		check_val("pin two idle", 1, alt_output_pin_two);
		release_bus(0);
		acquire(0);
		host_need = 1'b1;
		tick(3);
		check_val("grant kept", 0, grant_n);
		tick(1);
		check_val("reclaim", 1, grant_n);
		tick(2);
		check_val("gave back", 2'b11, {gfx_mem_request_n, reclaim_seen});
		host_need = 1'b0;
		want_bus = 1'b0;
		tick(4);
		cfg_write(OFS_CPU_CTRL, 8'h41);
		acquire(2);
		release_bus(2);
		cfg_write(OFS_CPU_CTRL, 8'h21);
		cpu_writeback_pending = 1'b1;
		pci_master_active = 1'b1;
		want_bus = 1'b1;
		tick(6);
		check_val("flush wait", 1, grant_n);
		check_val("pci disc", 1, pci_disconnect);
		check_val("arb hold", 1, arb_hold);
		cpu_writeback_pending = 1'b0;
		n = 0;
		while (grant_n !== 1'b0 && n < 5)
		begin
			tick(1);
			n++;
		end
		check_val("flush grant", 0, grant_n);
		pci_master_active = 1'b0;
		release_bus(0);
		// Release and reassert: high priority skips the flush after 22
		cpu_writeback_pending = 1'b1;
		want_bus = 1'b1;
		tick(4);
		want_bus = 1'b0;
		tick(1);
		want_bus = 1'b1;
		tick(19);
		check_val("rearm wait", 1, grant_n);
		tick(1);
		check_val("rearm grant", 0, grant_n);
		cpu_writeback_pending = 1'b0;
		release_bus(0);
		cfg_write(OFS_CPU_CTRL, 8'h01);
		cfg_write(OFS_LINK_CTRL, 8'h22);
		acquire(0);
		check_val("pin sel", 2'b10,
			{alt_output_pin_one, alt_output_pin_two});
		want_bus = 1'b0;
		n = 0;
		while (grant_n === 1'b0 && n < 40)
		begin
			tick(1);
			n++;
		end
		check_val("min width", 1, n >= 15 && n < 20);
		tick(3);
		cfg_write(OFS_CPU_CTRL, 8'h00);
		want_bus = 1'b1;
		tick(8);
		check_val("disabled", 2'b11, {grant_n, dram_ctl_oe});
		want_bus = 1'b0;
		tick(3);
		cfg_write(OFS_CPU_CTRL, 8'h01);
		cfg_write(OFS_WINDOW_CTRL, 8'h0C);
		cpu_addr = 32'h0008_0000;
		cpu_rd = 1'b1;
		tick(2);
		check_val("window hit", 1, direct_route);
		cpu_rd = 1'b0;
		tick(2);
		check_val("window idle", 0, direct_route);
		cpu_addr = 32'hA500_0000;
		cpu_wr = 1'b1;
		tick(2);
		check_val("hole hit", 1, direct_route);
		cpu_wr = 1'b0;
		conclude();
	end
endmodule : shared_memory_gfx_arbiter_tb_top
